//--- hdl/ata_wr_defs.svh
// Constants of the task-file write command engine
// Assumes a 4-bit register address and 16-bit data port
`ifndef ATA_WR_DEFS_SVH
`define ATA_WR_DEFS_SVH
`define A_DATA 4'h0
`define A_ERR_FEAT 4'h1
`define A_SCOUNT 4'h2
`define A_LBA_LO 4'h3
`define A_LBA_MID 4'h4
`define A_LBA_HI 4'h5
`define A_DEV 4'h6
`define A_STAT_CMD 4'h7
`define A_DEVCTL 4'h8
`define A_CONFIG 4'h9
`define A_IDENT_BLK 4'hA
`define A_QUEUE 4'hB
`define CMD_DMA_EXT 8'h35
`define CMD_FPDMA_WR 8'h61
`define CMD_WR_MULT 8'hC5
`define ST_BSY 7
`define ST_DRDY 6
`define ST_DRQ 3
`define ST_ERR 0
`define ER_UNC 6
`define ER_ABRT 2
`define DC_HOB 7
`define DEV_FUA 7
`define CFG_BYTE_MODE 0
`define CFG_MULT_SET 1
`define CFG_MULT_EN 2
`define CNT_WRAP 17'h10000
`define CNT_WRAP_MULT 17'h00100
`define CNT_ONE 17'h00001
`define MULT_BLOCK_MAX 8'h01
`define BSY_LIMIT_NS 400
`endif

//--- hdl/ata_wr_pkg.sv
// Types of the task-file write command engine
// Assumes nothing beyond the defs header
package ata_wr_pkg;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_PREP = 5'b00010,
    S_XFER = 5'b00100,
    S_MEDIA = 5'b01000,
    S_SPARE = 5'b10000
  } eng_state_e;
  typedef struct packed {
    logic [47:0] lba;
    logic fua;
    logic [4:0] tag;
  } media_cmd_s;
endpackage

//--- hdl/ata_write_command_engine.sv
// Write command engine behind an ATA-style task file
// Assumes a same-clock media back end and DMA pins from the host
//
// Function
// - 35h moves 1..65536 sectors, zero means 65536
// - On 35h raise busy, then data request
// - Hold DMA request while a sector fits
// - DMA write interrupts only at end or error
// - Success leaves last written address in registers
// - Error stops at failing sector, reports its address
// - Byte mode enabled aborts DMA writes
// - Previous/current bytes, high-order bit selects previous
// - 61h queued write moves host data inward
// - Forced access commits to media before completion
// - Without forced access early completion allowed
// - Queued count from features, tag from count
// - C5h sets busy within 400ns
// - Multiple write gates data per block only
// - Multiple write interrupts at each block start
// - Count is sectors, full blocks then remainder
// - Multiple write aborts unless configured and enabled
// - Multiple write error ends at failing sector
// - Error reports failing address and sectors left
// - Only block size one, reported in identify
// - Accept sets busy, then request, then wait
`include "ata_wr_defs.svh"

module ata_write_command_engine #(
  parameter int SECTOR_WORDS = 256,
  parameter logic [7:0] MULT_BLOCK = 8'h01
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic intrq,
  output logic dmarq,
  input wire logic dmack_b,
  input wire logic iowr_b,
  output logic media_req,
  output ata_wr_pkg::media_cmd_s media_cmd,
  input wire logic media_ack,
  input wire logic media_err
);
  import ata_wr_pkg::*;

  localparam int WCW = $clog2(SECTOR_WORDS);

  generate
    if (SECTOR_WORDS < 2 || SECTOR_WORDS > 256) begin : g_bad_words
      $error("SECTOR_WORDS out of range");
    end
    if (MULT_BLOCK != `MULT_BLOCK_MAX) begin : g_bad_block
      $error("Only a block size of one is served");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  eng_state_e state_r;
  logic [7:0] feat_cur_r, feat_prev_r, sc_cur_r, sc_prev_r;
  logic [7:0] lo_cur_r, lo_prev_r, mid_cur_r, mid_prev_r;
  logic [7:0] hi_cur_r, hi_prev_r, dev_r;
  logic hob_r;
  logic [2:0] cfg_r;
  logic bsy_r, drq_r, err_r, abrt_r, unc_r;
  logic pio_r, fua_r;
  logic [4:0] tag_r;
  logic [47:0] lba_r;
  logic [16:0] rem_r;
  logic [WCW-1:0] wcnt_r;
  logic rep_r, rep_pio_r;
  logic [47:0] rep_lba_r;
  logic [15:0] rep_cnt_r;
  logic dmack_s1_r, dmack_s2_r, iowr_s1_r, iowr_s2_r, iowr_s3_r;
  logic [15:0] rdata_r;
  logic intrq_r, dmarq_r, media_req_r;
  media_cmd_s media_cmd_r;
  logic idle, tf_wr, cmd_wr, stat_rd, word_stb;
  logic [15:0] sc16, feat16;
  logic [16:0] ext_cnt, ncq_cnt, mult_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  assign idle = (state_r == S_IDLE);
  assign tf_wr = wr && idle;
  assign cmd_wr = tf_wr && (addr == `A_STAT_CMD);
  assign stat_rd = rd && (addr == `A_STAT_CMD);
  assign sc16 = {sc_prev_r, sc_cur_r};
  assign feat16 = {feat_prev_r, feat_cur_r};
  assign ext_cnt = (sc16 == 16'h0000) ? `CNT_WRAP : {1'b0, sc16};
  assign ncq_cnt = (feat16 == 16'h0000) ? `CNT_WRAP : {1'b0, feat16};
  assign mult_cnt = (sc_cur_r == 8'h00) ? `CNT_WRAP_MULT
    : {9'h000, sc_cur_r};
  // Word strobe on a data-register write in PIO, else on the write pulse's trailing edge while acked
  assign word_stb = pio_r ? (wr && addr == `A_DATA && drq_r)
    : (iowr_s2_r && !iowr_s3_r && !dmack_s2_r && dmarq_r);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dmack_s1_r <= 1'b1;
      dmack_s2_r <= 1'b1;
      iowr_s1_r <= 1'b1;
      iowr_s2_r <= 1'b1;
      iowr_s3_r <= 1'b1;
    end else begin
      dmack_s1_r <= dmack_b;
      dmack_s2_r <= dmack_s1_r;
      iowr_s1_r <= iowr_b;
      iowr_s2_r <= iowr_s1_r;
      iowr_s3_r <= iowr_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Task file with previous and current bytes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      feat_cur_r <= 8'h00;
      feat_prev_r <= 8'h00;
      sc_cur_r <= 8'h00;
      sc_prev_r <= 8'h00;
      lo_cur_r <= 8'h00;
      lo_prev_r <= 8'h00;
      mid_cur_r <= 8'h00;
      mid_prev_r <= 8'h00;
      hi_cur_r <= 8'h00;
      hi_prev_r <= 8'h00;
      dev_r <= 8'h00;
      hob_r <= 1'b0;
      cfg_r <= 3'h0;
    end else if (rep_r) begin
      lo_cur_r <= rep_lba_r[7:0];
      mid_cur_r <= rep_lba_r[15:8];
      hi_cur_r <= rep_lba_r[23:16];
      lo_prev_r <= rep_lba_r[31:24];
      mid_prev_r <= rep_lba_r[39:32];
      hi_prev_r <= rep_lba_r[47:40];
      sc_cur_r <= rep_cnt_r[7:0];
      sc_prev_r <= rep_cnt_r[15:8];
      if (rep_pio_r) begin
        dev_r[3:0] <= rep_lba_r[27:24];
      end
    end else if (wr) begin
      if (addr == `A_DEVCTL) begin
        hob_r <= wdata[`DC_HOB];
      end else if (tf_wr) begin
        hob_r <= 1'b0;
        case (addr)
          `A_ERR_FEAT: begin
            feat_prev_r <= feat_cur_r;
            feat_cur_r <= wdata[7:0];
          end
          `A_SCOUNT: begin
            sc_prev_r <= sc_cur_r;
            sc_cur_r <= wdata[7:0];
          end
          `A_LBA_LO: begin
            lo_prev_r <= lo_cur_r;
            lo_cur_r <= wdata[7:0];
          end
          `A_LBA_MID: begin
            mid_prev_r <= mid_cur_r;
            mid_cur_r <= wdata[7:0];
          end
          `A_LBA_HI: begin
            hi_prev_r <= hi_cur_r;
            hi_cur_r <= wdata[7:0];
          end
          `A_DEV: dev_r <= wdata[7:0];
          `A_CONFIG: cfg_r <= wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command engine
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      bsy_r <= 1'b0;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      abrt_r <= 1'b0;
      unc_r <= 1'b0;
      pio_r <= 1'b0;
      fua_r <= 1'b0;
      tag_r <= 5'h00;
      lba_r <= 48'h0;
      rem_r <= 17'h0;
      wcnt_r <= '0;
      rep_r <= 1'b0;
      rep_pio_r <= 1'b0;
      rep_lba_r <= 48'h0;
      rep_cnt_r <= 16'h0000;
      intrq_r <= 1'b0;
      dmarq_r <= 1'b0;
      media_req_r <= 1'b0;
      media_cmd_r <= '0;
    end else begin
      rep_r <= 1'b0;
      media_req_r <= 1'b0;
      if (stat_rd) begin
        intrq_r <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (cmd_wr) begin
            err_r <= 1'b0;
            abrt_r <= 1'b0;
            unc_r <= 1'b0;
            fua_r <= 1'b0;
            tag_r <= 5'h00;
            case (wdata[7:0])
              `CMD_DMA_EXT, `CMD_FPDMA_WR: begin
                if (cfg_r[`CFG_BYTE_MODE]) begin
                  err_r <= 1'b1;
                  abrt_r <= 1'b1;
                  intrq_r <= 1'b1;
                end else begin
                  state_r <= S_PREP;
                  bsy_r <= 1'b1;
                  pio_r <= 1'b0;
                  lba_r <= {hi_prev_r, mid_prev_r, lo_prev_r,
                    hi_cur_r, mid_cur_r, lo_cur_r};
                  if (wdata[7:0] == `CMD_FPDMA_WR) begin
                    rem_r <= ncq_cnt;
                    tag_r <= sc_cur_r[7:3];
                    fua_r <= dev_r[`DEV_FUA];
                  end else begin
                    rem_r <= ext_cnt;
                  end
                end
              end
              `CMD_WR_MULT: begin
                if (!cfg_r[`CFG_MULT_SET] || !cfg_r[`CFG_MULT_EN]) begin
                  err_r <= 1'b1;
                  abrt_r <= 1'b1;
                  intrq_r <= 1'b1;
                end else begin
                  state_r <= S_PREP;
                  bsy_r <= 1'b1;
                  pio_r <= 1'b1;
                  rem_r <= mult_cnt;
                  lba_r <= {20'h00000, dev_r[3:0], hi_cur_r,
                    mid_cur_r, lo_cur_r};
                end
              end
              default: begin
                err_r <= 1'b1;
                abrt_r <= 1'b1;
                intrq_r <= 1'b1;
              end
            endcase
          end
        end
        S_PREP: begin
          bsy_r <= 1'b0;
          drq_r <= 1'b1;
          dmarq_r <= !pio_r;
          wcnt_r <= '0;
          if (pio_r) begin
            intrq_r <= 1'b1;
          end
          state_r <= S_XFER;
        end
        S_XFER: begin
          if (word_stb) begin
            wcnt_r <= wcnt_r + WCW'(1);
            if (wcnt_r == WCW'(SECTOR_WORDS - 1)) begin
              drq_r <= 1'b0;
              dmarq_r <= 1'b0;
              bsy_r <= 1'b1;
              media_req_r <= 1'b1;
              media_cmd_r <= '{lba: lba_r, fua: fua_r, tag: tag_r};
              state_r <= S_MEDIA;
            end
          end
        end
        S_MEDIA: begin
          if (media_ack) begin
            if (media_err) begin
              bsy_r <= 1'b0;
              err_r <= 1'b1;
              unc_r <= 1'b1;
              intrq_r <= 1'b1;
              rep_r <= 1'b1;
              rep_pio_r <= pio_r;
              rep_lba_r <= lba_r;
              rep_cnt_r <= rem_r[15:0];
              state_r <= S_IDLE;
            end else if (rem_r == `CNT_ONE) begin
              bsy_r <= 1'b0;
              intrq_r <= 1'b1;
              rep_r <= 1'b1;
              rep_pio_r <= pio_r;
              rep_lba_r <= lba_r;
              rep_cnt_r <= 16'h0000;
              state_r <= S_IDLE;
            end else begin
              rem_r <= rem_r - `CNT_ONE;
              lba_r <= lba_r + 48'h000000000001;
              state_r <= S_PREP;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
          bsy_r <= 1'b0;
          drq_r <= 1'b0;
          dmarq_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `A_ERR_FEAT: rdata_r <= {8'h00, 1'b0, unc_r, 3'h0, abrt_r, 2'h0};
        `A_SCOUNT: rdata_r <= {8'h00, hob_r ? sc_prev_r : sc_cur_r};
        `A_LBA_LO: rdata_r <= {8'h00, hob_r ? lo_prev_r : lo_cur_r};
        `A_LBA_MID: rdata_r <= {8'h00, hob_r ? mid_prev_r : mid_cur_r};
        `A_LBA_HI: rdata_r <= {8'h00, hob_r ? hi_prev_r : hi_cur_r};
        `A_DEV: rdata_r <= {8'h00, dev_r};
        `A_STAT_CMD, `A_DEVCTL: rdata_r <= {8'h00, bsy_r, 1'b1, 2'h0,
          drq_r, 2'h0, err_r};
        `A_CONFIG: rdata_r <= {13'h0000, cfg_r};
        `A_IDENT_BLK: rdata_r <= {8'h00, MULT_BLOCK};
        `A_QUEUE: rdata_r <= {10'h000, fua_r, tag_r};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata = rdata_r;
  assign intrq = intrq_r;
  assign dmarq = dmarq_r;
  assign media_req = media_req_r;
  assign media_cmd = media_cmd_r;
endmodule

//--- tb/ata_dma_host.sv
// Host DMA model: acks and strobes one word at a time
// Assumes the engine's DMA request and a running clock
module ata_dma_host (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic dmarq,
  input wire logic slow,
  output logic dmack_b,
  output logic iowr_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dmack_b = 1'b1;
    iowr_b = 1'b1;
    forever begin
      @(posedge clock);
      dmack_b <= !(rst_b && dmarq);
      if (rst_b && dmarq) begin
        iowr_b <= 1'b0;
        repeat (slow ? 8 : 4) @(posedge clock);
        iowr_b <= 1'b1;
        repeat (6) @(posedge clock);
      end
    end
  end
endmodule

//--- tb/ata_wr_engine_sva.sv
// Port checker of the write command engine
// Assumes it is bound onto the engine's top module
module ata_wr_engine_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic intrq,
  input wire logic dmarq,
  input wire logic media_req,
  input wire ata_wr_pkg::media_cmd_s media_cmd,
  input wire logic media_ack,
  input wire logic media_err
);
  timeunit 1ns;
  timeprecision 1ps;
  import ata_wr_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_rd_quiet:
    assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside read slot");
  a_ident_one:
    assert property ($past(rd) && $past(addr) == 4'hA |-> rdata == 16'h0001)
    else $error("block limit not one");
  a_dma_irq:
    assert property ($rose(intrq) |-> !dmarq)
    else $error("interrupt during DMA data phase");
  a_err_irq:
    assert property (media_ack && media_err |=> intrq)
    else $error("no interrupt after media error");
  a_dmarq_end:
    assert property ($fell(dmarq) |-> media_req)
    else $error("DMA request dropped before sector full");
  a_req_pulse:
    assert property (media_req |=> !media_req)
    else $error("media request longer than one cycle");
  a_req_gap:
    assert property (media_req |-> !dmarq ##1 !dmarq)
    else $error("DMA request while sector pending");
  a_cmd_hold:
    assert property (!media_req ##1 !media_req |-> $stable(media_cmd))
    else $error("media command moved without request");
  c_fua: cover property (media_req && media_cmd.fua);
  c_err: cover property (media_ack && media_err);
  c_dma_end: cover property ($fell(dmarq));
endmodule

bind ata_write_command_engine ata_wr_engine_sva u_sva (.clock, .rst_b,
  .addr, .rd, .rdata, .intrq, .dmarq, .media_req, .media_cmd, .media_ack,
  .media_err);

//--- tb/ata_write_command_engine_bench.sv
// Self-checking bench of the write command engine
// Assumes the host DMA model; the media back end lives here
module ata_write_command_engine_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ata_wr_pkg::*;
  localparam int SW = 4;
  logic clock, rst_b, wr, rd, slow, media_ack, media_err;
  logic intrq, dmarq, dmack_b, iowr_b, media_req;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [47:0] l, bad_lba;
  logic [4:0] tg;
  media_cmd_s media_cmd;
  media_cmd_s exp_q[$];
  int err_count, check_count, cyc;
  logic [15:0] ab[5] = '{16'h0135, 16'h0161, 16'h00C5, 16'h02C5, 16'h04C5};

  ata_write_command_engine #(.SECTOR_WORDS(SW)) u_dut (.clock, .rst_b,
    .addr, .wdata, .wr, .rd, .rdata, .intrq, .dmarq, .dmack_b, .iowr_b,
    .media_req, .media_cmd, .media_ack, .media_err);
  ata_dma_host u_host (.clock, .rst_b, .dmarq, .slow, .dmack_b, .iowr_b);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_media(input logic [53:0] got, input logic [53:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t media got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic cmd_go(input logic [7:0] op);
    wr <= 1'b1;
    addr <= 4'h7;
    wdata <= {8'h00, op};
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk_reg(rdata, 16'h00C0);
    @(posedge clock);
  endtask

  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk_reg(rdata, e);
    @(posedge clock);
  endtask

  task automatic wait_irq();
    do
      @(negedge clock);
    while (intrq !== 1'b1);
    @(posedge clock);
  endtask

  task automatic setup(input logic [15:0] c, f, input logic [7:0] dv);
    logic [15:0] v[1:5];
    v = '{f, c, {l[31:24], l[7:0]}, {l[39:32], l[15:8]},
      {l[47:40], l[23:16]}};
    for (int p = 1; p >= 0; p--)
      for (int i = 1; i <= 5; i++)
        wrr(4'(i), {8'h00, p ? v[i][15:8] : v[i][7:0]});
    wrr(4'h6, {8'h00, dv});
  endtask

  task automatic tf_chk(input logic [47:0] a, input logic [15:0] c, int top);
    logic [15:0] v[2:5];
    v = '{c, {a[31:24], a[7:0]}, {a[39:32], a[15:8]}, {a[47:40], a[23:16]}};
    for (int h = top; h >= 0; h--) begin
      wrr(4'h8, {8'h00, h[0], 7'h00});
      for (int i = 2; i <= 5; i++)
        rc(4'(i), {8'h00, h[0] ? v[i][15:8] : v[i][7:0]});
    end
  endtask

  task automatic plan(input int n, input logic fua, input int bo);
    bad_lba = l + 48'(bo);
    for (int i = 0; i < n; i++)
      exp_q.push_back('{l + 48'(i), fua, tg});
  endtask

  task automatic dma(input logic [7:0] op, input logic [15:0] c, f,
      input logic fua, input int n, bo);
    l = 48'({$urandom(), $urandom()});
    setup(c, f, {fua, 7'h40});
    plan(n, fua, bo);
    cmd_go(op);
    wait_irq();
    chk_reg(16'(exp_q.size()), 16'h0000);
  endtask

  initial begin
    media_ack = 1'b0;
    media_err = 1'b0;
    forever begin
      @(negedge clock);
      if (media_req === 1'b1) begin
        chk_media(media_cmd, exp_q[0]);
        if (exp_q.size() > 0)
          exp_q.delete(0);
        repeat ($urandom_range(3, 0)) @(posedge clock);
        @(posedge clock);
        media_ack <= 1'b1;
        media_err <= media_cmd.lba === bad_lba;
        @(posedge clock);
        media_ack <= 1'b0;
        media_err <= 1'b0;
      end
    end
  end

  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    slow = 1'b0;
    bad_lba = '1;
    tg = 5'h00;
    void'($urandom(87736));
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    rc(4'h7, 16'h0040);
    rc(4'hA, 16'h0001);
    rc(4'hC, 16'h0000);
    $display("test registers done");
    foreach (ab[i]) begin
      wrr(4'h9, {8'h00, ab[i][15:8]});
      wrr(4'h7, {8'h00, ab[i][7:0]});
      wait_irq();
      rc(4'h1, 16'h0004);
      rc(4'h7, 16'h0041);
    end
    wrr(4'h9, 16'h0000);
    $display("test aborts done");
    dma(8'h35, 16'h0003, 16'h0000, 1'b0, 3, -1);
    rc(4'h7, 16'h0040);
    tf_chk(l + 48'd2, 16'h0000, 1);
    dma(8'h35, 16'h0000, 16'h0000, 1'b0, 2, 1);
    rc(4'h7, 16'h0041);
    rc(4'h1, 16'h0040);
    tf_chk(l + 48'd1, 16'hFFFF, 1);
    $display("test dma done");
    slow <= 1'b1;
    for (int u = 0; u < 2; u++) begin
      tg = 5'($urandom());
      dma(8'h61, {8'h00, tg, 3'h0}, 16'h0002, u[0], 2, -1);
      rc(4'h7, 16'h0040);
      rc(4'hB, {10'h000, u[0], tg});
    end
    slow <= 1'b0;
    tg = 5'h00;
    $display("test queued done");
    wrr(4'h9, 16'h0006);
    l = 48'($urandom_range(32'h0FFFFFF0, 0));
    plan(2, 1'b0, 1);
    setup(16'h0003, 16'h0000, {4'hE, l[27:24]});
    cmd_go(8'hC5);
    for (int s = 0; s < 2; s++) begin
      wait_irq();
      rc(4'h7, 16'h0048);
      repeat (SW) wrr(4'h0, 16'($urandom()));
    end
    wait_irq();
    rc(4'h7, 16'h0041);
    chk_reg(16'(exp_q.size()), 16'h0000);
    tf_chk(l + 48'd1, 16'h0002, 0);
    $display("test multiple done");
    conclude();
  end
endmodule
